//--- src/cidd_pkg.sv
/*
 Package for the interrupt detect and dispatch block: interrupt numbers,
 control register indices, pipeline timing counts and dispatch states.
 Assumes a single core clock and a synchronous active-low reset.
*/
package cidd_pkg;

   // ************************************************************
   // Interrupt numbering
   // ************************************************************
   localparam int          NUM_INT      = 16;
   localparam int          NUM_W        = 4;
   localparam logic [3:0]  INT_RESET    = 4'h0;
   localparam logic [3:0]  INT_NMI      = 4'h1;
   localparam logic [3:0]  INT_MASK_LO  = 4'h4;
   localparam logic [15:0] MASKABLE_BITS = 16'hFFF0;
   localparam logic [15:0] NONRESET_BITS = 16'hFFF2;

   // ************************************************************
   // Control register indices on the move-to/from-control port
   // ************************************************************
   localparam logic [3:0]  REG_FLAG      = 4'h0;
   localparam logic [3:0]  REG_SET       = 4'h1;
   localparam logic [3:0]  REG_CLEAR     = 4'h2;
   localparam logic [3:0]  REG_ENABLE    = 4'h3;
   localparam logic [3:0]  REG_STATUS    = 4'h4;
   localparam logic [3:0]  REG_VECTOR    = 4'h5;
   localparam logic [3:0]  REG_MRET      = 4'h6;
   localparam logic [3:0]  REG_NRET      = 4'h7;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int          GIE_BIT       = 0;
   localparam int          SAVED_GLOBAL_ENABLE_BIT      = 1;
   localparam int          NMI_ENABLE_BIT      = 1;
   localparam int          RESET_EN_BIT  = 0;
   localparam int          VEC_NUM_LSB   = 5;
   localparam int          VEC_BASE_LSB  = 10;
   localparam logic [15:0] ENABLE_RST    = 16'h0001;
   localparam logic [31:0] ZERO32        = 32'h0000_0000;
   localparam logic [15:0] ZERO16        = 16'h0000;

   // ************************************************************
   // Pipeline timing, in clocks
   // ************************************************************
   localparam int          PIN_DELAY     = 2;
   localparam int          FLAG_DELAY    = 2;
   localparam int          BRANCH_WINDOW = 5;
   localparam int          OVERHEAD_FIX  = 7;
   localparam int          OVERHEAD_FLT  = 9;
   localparam int          RST_VEC_DELAY = 4;
   localparam logic [3:0]  CNT_ACK       = 4'h0;
   localparam logic [3:0]  CNT_CLR       = 4'h1;

   // ************************************************************
   // Dispatch states
   // ************************************************************
   typedef enum logic [3:0] {
      CIDD_IDLE  = 4'b0001,
      CIDD_DISP  = 4'b0010,
      CIDD_RWAIT = 4'b0100,
      CIDD_RDISP = 4'b1000
   } cidd_state_t;

endpackage

//--- src/cidd_core.sv
/*
 Interrupt detection and dispatch for a pipelined signal-processor core.
 Assumes the pipeline reports branch activity and the address of the
 oldest unexecuted packet, and honours the annul and forced-branch outputs.
*/
`timescale 1ns/1ns
module cidd_core #(
   parameter bit FLOAT_VARIANT = 1'b0
) (
   // Clock, reset and enable
   input  wire logic        clk_sys_in,
   input  wire logic        resetn_in,
   input  wire logic        ce_in,
   // External interrupt pins
   input  wire logic [15:0] interrupt_input_m_in,
   // Control register port
   input  wire logic        ctl_wr_in,
   input  wire logic        ctl_rd_in,
   input  wire logic [3:0]  ctl_idx_in,
   input  wire logic [31:0] ctl_wdata_in,
   output logic      [31:0] ctl_rdata_out,
   // Pipeline status
   input  wire logic        branch_in_window_in,
   input  wire logic [31:0] next_packet_addr_in,
   input  wire logic        ret_nmi_done_in,
   input  wire logic        ret_mask_done_in,
   // Pipeline control
   output logic             annul_out,
   output logic             flush_out,
   output logic             force_branch_out,
   output logic      [31:0] branch_target_out,
   // Acknowledge
   output logic             interrupt_ack_out,
   output logic      [3:0]  interrupt_number_out
);

   // ************************************************************
   // Timing derived from the variant
   // ************************************************************
   localparam logic [3:0] OVERHEAD = FLOAT_VARIANT ? 4'(cidd_pkg::OVERHEAD_FLT)
                                                   : 4'(cidd_pkg::OVERHEAD_FIX);
   localparam logic [3:0] BR_CNT   = FLOAT_VARIANT
                                     ? 4'(cidd_pkg::CNT_ACK + cidd_pkg::OVERHEAD_FLT
                                          - cidd_pkg::OVERHEAD_FIX)
                                     : cidd_pkg::CNT_ACK;
   // Leaving one count early makes the take cycle the first of the blocked cycles.
   localparam logic [3:0] EXIT_CNT = OVERHEAD - 4'h2;
   localparam logic [2:0] RST_WAIT = 3'(cidd_pkg::RST_VEC_DELAY - 1);

   // ************************************************************
   // State
   // ************************************************************
   logic [15:0]               pin_q [cidd_pkg::PIN_DELAY];
   logic [15:0]               bnd_q;
   logic [15:0]               det_q [cidd_pkg::FLAG_DELAY];
   logic [15:0]               flag_q;
   logic [15:0]               enable_q;
   logic                      gie_q;
   logic                      saved_global_enable_q;
   logic                      nmi_enable_q;
   logic [21:0]               vbase_q;
   logic [3:0]                vnum_q;
   logic [31:0]               nret_q;
   logic [31:0]               mret_q;
   logic [3:0]                cnt_q;
   logic [3:0]                num_q;
   logic [2:0]                rcnt_q;
   logic                      rst_seen_q;
   cidd_pkg::cidd_state_t     state_q;
   cidd_pkg::cidd_state_t     state_d;

   // ************************************************************
   // Decode and priority
   // ************************************************************
   wire        wr_set   = ctl_wr_in && ctl_idx_in == cidd_pkg::REG_SET;
   wire        wr_clr   = ctl_wr_in && ctl_idx_in == cidd_pkg::REG_CLEAR;
   wire        wr_en    = ctl_wr_in && ctl_idx_in == cidd_pkg::REG_ENABLE;
   wire        wr_stat  = ctl_wr_in && ctl_idx_in == cidd_pkg::REG_STATUS;
   wire        wr_vec   = ctl_wr_in && ctl_idx_in == cidd_pkg::REG_VECTOR;
   wire        wr_mret  = ctl_wr_in && ctl_idx_in == cidd_pkg::REG_MRET;
   wire        wr_nret  = ctl_wr_in && ctl_idx_in == cidd_pkg::REG_NRET;
   // The boundary level is compared with its own previous value, so a pin held
   // high sets its flag once and not again every other clock.
   wire [15:0] bnd_in   = pin_q[cidd_pkg::PIN_DELAY-1];
   wire [15:0] rise     = bnd_in & ~bnd_q;
   wire [15:0] hw_set   = det_q[cidd_pkg::FLAG_DELAY-1];
   wire [15:0] sw_bits  = ctl_wdata_in[15:0] & cidd_pkg::MASKABLE_BITS;
   wire [15:0] sw_set   = wr_set ? sw_bits : cidd_pkg::ZERO16;
   wire [15:0] sw_clr   = wr_clr && !wr_set ? sw_bits : cidd_pkg::ZERO16;
   wire [15:0] enable_view = {enable_q[15:2], nmi_enable_q, enable_q[0]};
   // A maskable source also needs the global enable; NMI only its enable.
   wire [15:0] gated    = {flag_q[15:4] & enable_q[15:4] & {12{gie_q}},
                           2'b00, flag_q[1] & nmi_enable_q, 1'b0};
   wire        any_pend = |flag_q[15:1] ;
   logic [3:0] top_num;
   logic       top_hit;
   logic       higher;

   always_comb begin
      top_num = cidd_pkg::INT_RESET;
      top_hit = 1'b0;
      higher  = 1'b0;
      for (int i = cidd_pkg::NUM_INT - 1; i >= 1; i--) begin
         if (flag_q[i] && gated[i]) begin
            top_num = 4'(i);
            top_hit = 1'b1;
         end
      end
      // A higher pending flag that is itself not enabled still blocks the winner.
      for (int j = 1; j < cidd_pkg::NUM_INT; j++) begin
         if (flag_q[j] && 4'(j) < top_num) begin
            higher = 1'b1;
         end
      end
   end

   wire prio_ok = top_hit && !higher;
   wire idle_ok = state_q == cidd_pkg::CIDD_IDLE;
   wire pipe_ok = !branch_in_window_in;
   wire take = idle_ok && prio_ok && nmi_enable_q
               && pipe_ok && any_pend;
   wire is_nmi = top_num == cidd_pkg::INT_NMI;
   wire clr_now = state_q == cidd_pkg::CIDD_DISP && cnt_q == cidd_pkg::CNT_CLR;
   wire [15:0] proc_clr = clr_now ? (16'h0001 << num_q) & cidd_pkg::NONRESET_BITS
                                  : cidd_pkg::ZERO16;
   wire [31:0] vec_ptr  = {vbase_q, 1'b0, vnum_q, 5'b00000};

   // ************************************************************
   // Dispatch sequencer
   // ************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         cidd_pkg::CIDD_IDLE: begin
            if (rst_seen_q) begin
               state_d = cidd_pkg::CIDD_RWAIT;
            end else if (take) begin
               state_d = cidd_pkg::CIDD_DISP;
            end
         end
         cidd_pkg::CIDD_DISP: begin
            if (cnt_q == EXIT_CNT) begin
               state_d = cidd_pkg::CIDD_IDLE;
            end
         end
         cidd_pkg::CIDD_RWAIT: begin
            if (rcnt_q == RST_WAIT) begin
               state_d = cidd_pkg::CIDD_RDISP;
            end
         end
         cidd_pkg::CIDD_RDISP: begin
            state_d = cidd_pkg::CIDD_IDLE;
         end
         default: begin
            state_d = cidd_pkg::CIDD_IDLE;
         end
      endcase
   end

   // ************************************************************
   // Edge detection runs on every enabled clock, stalls or not
   // ************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         for (int k = 0; k < cidd_pkg::PIN_DELAY; k++) begin
            pin_q[k] <= cidd_pkg::ZERO16;
         end
         for (int k = 0; k < cidd_pkg::FLAG_DELAY; k++) begin
            det_q[k] <= cidd_pkg::ZERO16;
         end
         bnd_q <= cidd_pkg::ZERO16;
      end else if (ce_in) begin
         pin_q[0] <= interrupt_input_m_in;
         for (int k = 1; k < cidd_pkg::PIN_DELAY; k++) begin
            pin_q[k] <= pin_q[k-1];
         end
         bnd_q    <= bnd_in;
         det_q[0] <= rise & cidd_pkg::NONRESET_BITS;
         for (int k = 1; k < cidd_pkg::FLAG_DELAY; k++) begin
            det_q[k] <= det_q[k-1];
         end
      end
   end

   // ************************************************************
   // Flags: hardware set has the last word over any clear
   // ************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         flag_q <= cidd_pkg::ZERO16;
      end else if (ce_in) begin
         flag_q <= (flag_q & ~proc_clr & ~sw_clr)
                   | sw_set | hw_set;
      end
   end

   // ************************************************************
   // Enables and status
   // ************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         enable_q <= cidd_pkg::ENABLE_RST;
         gie_q    <= 1'b0;
         saved_global_enable_q   <= 1'b0;
         nmi_enable_q   <= 1'b0;
         vbase_q  <= 22'h000000;
         vnum_q   <= cidd_pkg::INT_RESET;
      end else if (ce_in) begin
         if (wr_en) begin
            enable_q <= (ctl_wdata_in[15:0] & cidd_pkg::MASKABLE_BITS)
                        | cidd_pkg::ENABLE_RST;
         end
         if (wr_vec) begin
            vbase_q <= ctl_wdata_in[31:cidd_pkg::VEC_BASE_LSB];
         end
         if (take) begin
            vnum_q <= top_num;
            if (is_nmi) begin
               nmi_enable_q <= 1'b0;
            end else begin
               saved_global_enable_q <= wr_stat ? ctl_wdata_in[cidd_pkg::GIE_BIT] : gie_q;
               gie_q  <= 1'b0;
            end
         end else begin
            if (ret_mask_done_in) begin
               gie_q <= saved_global_enable_q;
            end else if (wr_stat) begin
               gie_q  <= ctl_wdata_in[cidd_pkg::GIE_BIT];
               saved_global_enable_q <= ctl_wdata_in[cidd_pkg::SAVED_GLOBAL_ENABLE_BIT];
            end
            if (ret_nmi_done_in || (wr_en && ctl_wdata_in[cidd_pkg::NMI_ENABLE_BIT])) begin
               nmi_enable_q <= 1'b1;
            end
         end
         if (state_q == cidd_pkg::CIDD_RWAIT) begin
            vnum_q <= cidd_pkg::INT_RESET;
         end
      end
   end

   // ************************************************************
   // Return pointers and sequencer registers
   // ************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         nret_q     <= cidd_pkg::ZERO32;
         mret_q     <= cidd_pkg::ZERO32;
         state_q    <= cidd_pkg::CIDD_IDLE;
         cnt_q      <= 4'h0;
         num_q      <= cidd_pkg::INT_RESET;
         rcnt_q     <= 3'b000;
         rst_seen_q <= 1'b1;
      end else if (ce_in) begin
         state_q <= state_d;
         if (take && is_nmi) begin
            nret_q <= next_packet_addr_in;
         end else if (wr_nret) begin
            nret_q <= ctl_wdata_in;
         end
         if (take && !is_nmi) begin
            mret_q <= next_packet_addr_in;
         end else if (wr_mret) begin
            mret_q <= ctl_wdata_in;
         end
         cnt_q  <= (state_q == cidd_pkg::CIDD_DISP) ? cnt_q + 4'h1 : 4'h0;
         rcnt_q <= (state_q == cidd_pkg::CIDD_RWAIT) ? rcnt_q + 3'b001 : 3'b000;
         if (take) begin
            num_q <= top_num;
         end
         // The reset flag stays readable until its own dispatch has been acknowledged.
         if (state_q == cidd_pkg::CIDD_RDISP) begin
            rst_seen_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   wire in_disp = state_q == cidd_pkg::CIDD_DISP;
   wire at_ack  = in_disp && cnt_q == cidd_pkg::CNT_ACK;
   wire r_ack   = state_q == cidd_pkg::CIDD_RDISP;
   wire at_force = in_disp && cnt_q == BR_CNT;

   // The forced branch lands later on the slower variant; ack keeps its slot.
   assign annul_out            = take || in_disp;
   assign flush_out            = !resetn_in || state_q == cidd_pkg::CIDD_RWAIT;
   assign force_branch_out     = at_force || r_ack;
   assign branch_target_out    = vec_ptr;
   assign interrupt_ack_out    = at_ack || r_ack;
   assign interrupt_number_out = r_ack ? cidd_pkg::INT_RESET : (at_ack ? num_q : 4'h0);

   // Bit 1 of the enable word reads nmi_enable itself, which hardware may clear.
   logic [31:0] rd_mux;
   always_comb begin
      case (ctl_idx_in)
         cidd_pkg::REG_FLAG:   rd_mux = {16'h0000, flag_q[15:1], rst_seen_q};
         cidd_pkg::REG_ENABLE: rd_mux = {16'h0000, enable_view};
         cidd_pkg::REG_STATUS: rd_mux = {30'h00000000, saved_global_enable_q, gie_q};
         cidd_pkg::REG_VECTOR: rd_mux = vec_ptr;
         cidd_pkg::REG_MRET:   rd_mux = mret_q;
         cidd_pkg::REG_NRET:   rd_mux = nret_q;
         default:              rd_mux = cidd_pkg::ZERO32;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         ctl_rdata_out <= cidd_pkg::ZERO32;
      end else if (ce_in && ctl_rd_in) begin
         ctl_rdata_out <= rd_mux;
      end
   end

endmodule

//--- tb/cidd_core_monitor.sv
/*
 Concurrent checks on the ports of the interrupt detect and dispatch core.
 Assumes the single core clock and the synchronous active-low reset.
*/
`timescale 1ns/1ns
module cidd_core_monitor #(
   parameter bit FLOAT_VARIANT = 1'b0
) (
   // Clock and reset
   input wire logic        clk_sys_in,
   input wire logic        resetn_in,
   // Pipeline side
   input wire logic        branch_in_window_in,
   input wire logic        annul_out,
   input wire logic        flush_out,
   input wire logic        force_branch_out,
   input wire logic [31:0] branch_target_out,
   // Acknowledge
   input wire logic        interrupt_ack_out,
   input wire logic [3:0]  interrupt_number_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   // ************************************************************
   // Sequences
   // ************************************************************
   sequence s_take;
      $rose(annul_out) && !flush_out && !interrupt_ack_out;
   endsequence
   sequence s_reset_disp;
      force_branch_out && interrupt_ack_out && interrupt_number_out == 4'h0;
   endsequence
   sequence s_ack_num;
      interrupt_ack_out && interrupt_number_out != 4'h0;
   endsequence

   // ************************************************************
   // Properties
   // ************************************************************
   a_take_ack_delay: assert property (s_take |-> ##1 s_ack_num)
      else $error("ack not one cycle after take");
   a_take_no_branch: assert property (s_take |-> !branch_in_window_in)
      else $error("take during branch window");
   a_ack_annul: assert property (s_ack_num |-> annul_out)
      else $error("ack without annul");
   a_ack_gap: assert property (interrupt_ack_out |=> (!interrupt_ack_out) [*6])
      else $error("second take inside processing");
   a_number_idle: assert property (
      !interrupt_ack_out |-> interrupt_number_out == 4'h0)
      else $error("number driven without ack");
   a_vector_target: assert property (
      interrupt_ack_out && interrupt_number_out != 4'h0 && !FLOAT_VARIANT
      |-> force_branch_out && branch_target_out[9:0] == {1'b0, interrupt_number_out, 5'h00})
      else $error("forced branch target wrong");
   a_force_cause: assert property (
      force_branch_out |-> interrupt_ack_out
      || (FLOAT_VARIANT ? $past(interrupt_ack_out, 2) : 1'b0))
      else $error("forced branch without ack");
   a_reset_vector: assert property (
      $rose(resetn_in) |-> (!interrupt_ack_out) [*3] ##[1:5] s_reset_disp)
      else $error("reset vector not dispatched");
   a_reset_flush: assert property ($rose(resetn_in) |-> ##[1:3] flush_out [*4])
      else $error("no flush after reset");
endmodule

bind cidd_core cidd_core_monitor #(.FLOAT_VARIANT(FLOAT_VARIANT)) cidd_core_monitor_inst (
   .clk_sys_in(clk_sys_in),
   .resetn_in(resetn_in),
   .branch_in_window_in(branch_in_window_in),
   .annul_out(annul_out),
   .flush_out(flush_out),
   .force_branch_out(force_branch_out),
   .branch_target_out(branch_target_out),
   .interrupt_ack_out(interrupt_ack_out),
   .interrupt_number_out(interrupt_number_out)
);

//--- tb/cidd_irq_source.sv
/*
 Model of the interrupt sources and the external acknowledge logic.
 Assumes the bench requests pulses on the core clock's falling edge.
*/
`timescale 1ns/1ns
module cidd_irq_source (
   // Clock and bench requests
   input  wire logic        clk_sys_in,
   input  wire logic        fire_in,
   input  wire logic [15:0] fire_mask_in,
   // Core acknowledge side
   input  wire logic        interrupt_ack_in,
   input  wire logic [3:0]  interrupt_number_in,
   input  wire logic        force_branch_in,
   input  wire logic [31:0] branch_target_in,
   // Pins and captured answers
   output logic      [15:0] pins_out,
   output logic      [3:0]  last_num_out,
   output logic      [31:0] last_target_out,
   output int               ack_count_out
);
   logic [1:0] hold_q;
   initial begin
      pins_out = 16'h0000;
      hold_q = 2'h0;
      last_num_out = 4'hF;
      last_target_out = 32'hFFFF_FFFF;
      ack_count_out = 0;
   end
   // Pins are held a few clocks so the edge survives the boundary delay.
   always @(posedge clk_sys_in) begin
      if (fire_in) begin
         pins_out <= fire_mask_in;
         hold_q <= 2'h3;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end else begin
         pins_out <= 16'h0000;
      end
      if (interrupt_ack_in) begin
         last_num_out <= interrupt_number_in;
         ack_count_out <= ack_count_out + 1;
      end
      if (force_branch_in) begin
         last_target_out <= branch_target_in;
      end
   end
endmodule

//--- tb/tb_cidd_core.sv
/*
 Self-checking bench for the interrupt detect and dispatch core.
 Assumes the fixed-point variant and the source model beside it.
*/
`timescale 1ns/1ns
module tb_cidd_core;
   logic clk_sys_in, resetn_in, ctl_wr_in, ctl_rd_in, branch_in_window_in;
   logic ret_nmi_done_in, ret_mask_done_in, annul_out, flush_out, force_branch_out;
   logic interrupt_ack_out, fire;
   logic [3:0]  ctl_idx_in, interrupt_number_out, last_num;
   logic [15:0] pins, fire_mask;
   logic [31:0] ctl_wdata_in, ctl_rdata_out, next_packet_addr_in, branch_target_out, last_target;
   int          ack_count, n_errors, checks_done, last_wait;

   cidd_core #(.FLOAT_VARIANT(1'b0)) cidd_core_inst (.clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in), .ce_in(1'b1), .interrupt_input_m_in(pins),
      .ctl_wr_in(ctl_wr_in), .ctl_rd_in(ctl_rd_in), .ctl_idx_in(ctl_idx_in),
      .ctl_wdata_in(ctl_wdata_in), .ctl_rdata_out(ctl_rdata_out),
      .branch_in_window_in(branch_in_window_in), .next_packet_addr_in(next_packet_addr_in),
      .ret_nmi_done_in(ret_nmi_done_in), .ret_mask_done_in(ret_mask_done_in),
      .annul_out(annul_out), .flush_out(flush_out), .force_branch_out(force_branch_out),
      .branch_target_out(branch_target_out), .interrupt_ack_out(interrupt_ack_out),
      .interrupt_number_out(interrupt_number_out));
   cidd_irq_source cidd_irq_source_inst (.clk_sys_in(clk_sys_in), .fire_in(fire),
      .fire_mask_in(fire_mask), .interrupt_ack_in(interrupt_ack_out),
      .interrupt_number_in(interrupt_number_out), .force_branch_in(force_branch_out),
      .branch_target_in(branch_target_out), .pins_out(pins), .last_num_out(last_num),
      .last_target_out(last_target), .ack_count_out(ack_count));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      @(negedge clk_sys_in);
      ctl_wr_in = 1'b1;
      ctl_idx_in = idx;
      ctl_wdata_in = d;
      @(negedge clk_sys_in);
      ctl_wr_in = 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [3:0] idx, input logic [31:0] exp);
      @(negedge clk_sys_in);
      ctl_rd_in = 1'b1;
      ctl_idx_in = idx;
      @(negedge clk_sys_in);
      ctl_rd_in = 1'b0;
      check(what, ctl_rdata_out, exp);
   endtask
   task automatic pulse(input int which, input logic [15:0] mask);
      @(negedge clk_sys_in);
      fire_mask = mask;
      if (which == 0) fire = 1'b1;
      else if (which == 1) ret_mask_done_in = 1'b1;
      else ret_nmi_done_in = 1'b1;
      @(negedge clk_sys_in);
      fire = 1'b0;
      ret_mask_done_in = 1'b0;
      ret_nmi_done_in = 1'b0;
   endtask
   // Waits for one acknowledge, then lets the forced branch land.
   task automatic wait_ack(input logic [3:0] num, input logic [31:0] target);
      int c0;
      int k;
      c0 = ack_count;
      k = 0;
      while (ack_count == c0 && k < 80) begin
         @(negedge clk_sys_in);
         k++;
      end
      last_wait = k;
      repeat (3) @(negedge clk_sys_in);
      check("ack count", 32'(ack_count - c0), 32'h0000_0001);
      check("ack number", {28'h0, last_num}, {28'h0, num});
      check("vector target", last_target, target);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      wait_ack(4'h0, 32'h0000_0000);
      rd_chk("enable", 4'h3, 32'h0000_0001);
      rd_chk("flag", 4'h0, 32'h0000_0000);
      rd_chk("status", 4'h4, 32'h0000_0000);
      rd_chk("unmapped", 4'hF, 32'h0000_0000);
      wr(4'h3, 32'h0000_0000);
      rd_chk("enable bit0", 4'h3, 32'h0000_0001);
   endtask
   task automatic t_flags();
      wr(4'h1, 32'h0000_0022);
      rd_chk("flag set", 4'h0, 32'h0000_0020);
      wr(4'h2, 32'h0000_0000);
      rd_chk("clear zero", 4'h0, 32'h0000_0020);
      wr(4'h2, 32'h0000_0020);
      rd_chk("flag clear", 4'h0, 32'h0000_0000);
   endtask
   task automatic t_mask();
      int c0;
      wr(4'h3, 32'h0000_0062);
      wr(4'h5, 32'h1234_5C00);
      wr(4'h4, 32'h0000_0001);
      next_packet_addr_in = 32'hA0A0_0040;
      branch_in_window_in = 1'b1;
      c0 = ack_count;
      pulse(0, 16'h0060);
      repeat (20) @(negedge clk_sys_in);
      check("held by branch", 32'(ack_count - c0), 32'h0000_0000);
      rd_chk("both flags", 4'h0, 32'h0000_0060);
      branch_in_window_in = 1'b0;
      wait_ack(4'h5, 32'h1234_5CA0);
      rd_chk("mask return", 4'h6, 32'hA0A0_0040);
      rd_chk("status saved", 4'h4, 32'h0000_0002);
      rd_chk("loser flag", 4'h0, 32'h0000_0040);
      pulse(1, 16'h0000);
      wait_ack(4'h6, 32'h1234_5CC0);
      rd_chk("flags done", 4'h0, 32'h0000_0000);
      wr(4'h6, 32'h5555_0000);
      rd_chk("sw return", 4'h6, 32'h5555_0000);
   endtask
   task automatic t_nmi();
      int c0;
      next_packet_addr_in = 32'hB0B0_0080;
      pulse(0, 16'h0002);
      wait_ack(4'h1, 32'h1234_5C20);
      check("nmi latency", 32'(last_wait), 32'h0000_0007);
      rd_chk("nmi return", 4'h7, 32'hB0B0_0080);
      rd_chk("nmi_enable clear", 4'h3, 32'h0000_0061);
      wr(4'h4, 32'h0000_0001);
      c0 = ack_count;
      wr(4'h1, 32'h0000_0020);
      repeat (20) @(negedge clk_sys_in);
      check("nmi_enable blocks", 32'(ack_count - c0), 32'h0000_0000);
      pulse(2, 16'h0000);
      wait_ack(4'h5, 32'h1234_5CA0);
      rd_chk("nmi_enable set", 4'h3, 32'h0000_0063);
   endtask

   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      #200000;
      n_errors++;
      conclude();
   end
   initial begin
      {resetn_in, ctl_wr_in, ctl_rd_in, branch_in_window_in, fire} = 5'h00;
      {ret_nmi_done_in, ret_mask_done_in, ctl_idx_in, fire_mask} = 22'h000000;
      {ctl_wdata_in, next_packet_addr_in} = 64'h0;
      n_errors = 0;
      checks_done = 0;
      repeat (12) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      t_reset();
      t_flags();
      t_mask();
      t_nmi();
      conclude();
   end
endmodule
